// ### tmsel_pkg.sv
// shared constants and types for the tdm multichannel selection block
package tmsel_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NCHAN = 128;
    localparam int unsigned CHAN_W = 7;
    localparam int unsigned NUM_EN = 4;
    localparam int unsigned ADDR_W = 6;

    // register byte offsets
    localparam logic [5:0] OFS_MCR = 6'h00;
    localparam logic [5:0] OFS_TXEN0 = 6'h04;
    localparam logic [5:0] OFS_RXEN0 = 6'h14;
    localparam logic [5:0] OFS_STEP = 6'h04;

    // control register field positions
    localparam int unsigned POS_TX_ENH = 25;
    localparam int unsigned POS_TX_B = 23;
    localparam int unsigned POS_TX_A = 21;
    localparam int unsigned POS_TX_CUR = 18;
    localparam int unsigned POS_TX_MODE = 16;
    localparam int unsigned POS_RX_ENH = 9;
    localparam int unsigned POS_RX_B = 7;
    localparam int unsigned POS_RX_A = 5;
    localparam int unsigned POS_RX_CUR = 2;
    localparam int unsigned POS_RX_EN = 0;

    // reset values
    localparam logic [1:0] BLK_RST = 2'h0;
    localparam logic [31:0] WORD_RST = 32'h0;

    typedef enum logic [1:0] {
        TXM_ALL = 2'b00,
        TXM_SEL = 2'b01,
        TXM_MASK = 2'b10,
        TXM_SYM = 2'b11
    } tmsel_txmode_e;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_RESP = 1'b1
    } tmsel_bus_e;

    // slot timing strobes from the serial framer
    typedef struct packed {
        logic frameSync;
        logic slotTick;
        logic gap;
    } tmsel_slot_s;
endpackage

// ### tmsel_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module tmsel_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign push = inValid && inReady;
    assign pop = outReady && outValid;
    assign outData = mem[rdPtr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // flags registered so the ready seen outside is a flop
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count <= '0;
            inReady <= 1'b0;
            outValid <= 1'b0;
        end else begin
            count <= next_count;
            inReady <= next_count != FULL_CNT;
            outValid <= next_count != '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + 1'b1;
            end
        end
    end

    // storage needs no reset, valid guards it
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end
endmodule // tmsel_fifo

// ### tmsel_slot_counter.sv
// channel slot counter within one tdm frame
`timescale 1ns/1ps
module tmsel_slot_counter (
    input wire logic clk_sys,
    input wire logic reset,
    input wire tmsel_pkg::tmsel_slot_s slot,
    output logic [tmsel_pkg::CHAN_W-1:0] chan,
    output logic [2:0] curBlock,
    output logic slotStart
);
    localparam logic [tmsel_pkg::CHAN_W-1:0] LAST_CHAN = 7'h7F;

    // channel index, zero on frame sync
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            chan <= '0;
            slotStart <= 1'b0;
        end else if (slot.frameSync) begin
            chan <= '0;
            slotStart <= 1'b1;
        end else if (slot.slotTick && chan != LAST_CHAN) begin
            chan <= chan + 1'b1;
            slotStart <= 1'b1;
        end else begin
            // slots past the last channel are ignored
            slotStart <= 1'b0;
        end
    end

    // one subframe every sixteen slots
    assign curBlock = chan[6:4];
endmodule // tmsel_slot_counter

// ### tmsel_select.sv
// tdm multichannel selection: control register, channel enable and masking
// Contract
// - unused control register bits read zero and ignore writes
// - enhanced 128-channel selection exists only when the variant parameter allows it
// - transmit enhanced bit 25: 0 normal 32-channel, 1 uses 128-bit enables
// - receive enhanced bit 9: 0 normal 32-channel, 1 uses 128-bit enables
// - transmit part B block 0..3 picks odd subframe 1,3,5,7
// - transmit part A block 0..3 picks even subframe 0,2,4,6
// - transmit current block reports subframe now transmitted, channels 16n..16n+15
// - transmit mode 0 enables and unmasks every channel, data always driven
// - output released between packets, on masked channels and on disabled ones
// - transmit mode 1 drives only selected channels, others disabled and masked
// - transmit mode 2 enables all channels, unmasks only selected ones
// - transmit mode 3 enables by receive selection, unmasks by transmit enables
// - receive part B block 0 selects channels 16 to 31
// - receive part B block 1,2,3 select subframes 3,5,7
// - receive part A block 0..3 picks even subframe 0,2,4,6
// - receive current block reports subframe now received, 0 to 7
// - receive enable bit 0 enables all; 1 receives only selected channels
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module tmsel_select #(
    parameter bit ENH_SUPPORT = 1'b1,
    parameter int unsigned FIFO_DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [tmsel_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [tmsel_pkg::DATA_W-1:0] txWordData,
    input wire logic txWordValid,
    output logic txWordReady,
    input wire tmsel_pkg::tmsel_slot_s txSlot,
    input wire tmsel_pkg::tmsel_slot_s rxSlot,
    output logic [tmsel_pkg::DATA_W-1:0] serialDataOut,
    output logic serialDataOutEn_n,
    output logic rxChanEnabled
);
    // control fields
    logic txEnh;
    logic [1:0] txPartB;
    logic [1:0] txPartA;
    tmsel_pkg::tmsel_txmode_e txMode;
    logic rxEnh;
    logic [1:0] rxPartB;
    logic [1:0] rxPartA;
    logic rxSelEn;

    // channel enable words, word 0 holds partition A low, B high
    logic [tmsel_pkg::NUM_EN-1:0][31:0] txEnReg;
    logic [tmsel_pkg::NUM_EN-1:0][31:0] rxEnReg;

    tmsel_pkg::tmsel_bus_e busState;
    logic wrStrobe;
    logic [31:0] mcrView;
    logic [31:0] rdMux;

    logic [tmsel_pkg::CHAN_W-1:0] txChan;
    logic [tmsel_pkg::CHAN_W-1:0] rxChan;
    logic [2:0] txCurBlock;
    logic [2:0] rxCurBlock;
    logic txStart;
    logic rxStart;

    logic txHit;
    logic rxHitTx;
    logic txEnabled;
    logic txUnmasked;
    logic rxHit;

    logic [tmsel_pkg::DATA_W-1:0] fifoData;
    logic fifoValid;
    logic fifoPop;

    // normal or enhanced channel lookup
    function automatic logic chanSel(
        input logic [6:0] ch,
        input logic [1:0] pa,
        input logic [1:0] pb,
        input logic enh,
        input logic [127:0] en
    );
        logic hit;
        hit = 1'b0;
        if (enh) begin
            hit = en[ch];
        end else if (!ch[4] && ch[6:5] == pa) begin
            hit = en[{3'b000, ch[3:0]}];
        end else if (ch[4] && ch[6:5] == pb) begin
            hit = en[{3'b001, ch[3:0]}];
        end
        return hit;
    endfunction

    // avalon slave: one wait state, then the answer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            busState <= tmsel_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            case (busState)
                tmsel_pkg::BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        busState <= tmsel_pkg::BUS_RESP;
                        avs_waitrequest <= 1'b0;
                    end
                end
                tmsel_pkg::BUS_RESP: begin
                    busState <= tmsel_pkg::BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    busState <= tmsel_pkg::BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // writes land at the edge where waitrequest is seen low
    assign wrStrobe = busState == tmsel_pkg::BUS_RESP && avs_write;

    // control register view, unused positions stay zero
    always_comb begin
        mcrView = tmsel_pkg::WORD_RST;
        mcrView[tmsel_pkg::POS_TX_ENH] = txEnh;
        mcrView[tmsel_pkg::POS_TX_B +: 2] = txPartB;
        mcrView[tmsel_pkg::POS_TX_A +: 2] = txPartA;
        mcrView[tmsel_pkg::POS_TX_CUR +: 3] = txCurBlock;
        mcrView[tmsel_pkg::POS_TX_MODE +: 2] = txMode;
        mcrView[tmsel_pkg::POS_RX_ENH] = rxEnh;
        mcrView[tmsel_pkg::POS_RX_B +: 2] = rxPartB;
        mcrView[tmsel_pkg::POS_RX_A +: 2] = rxPartA;
        mcrView[tmsel_pkg::POS_RX_CUR +: 3] = rxCurBlock;
        mcrView[tmsel_pkg::POS_RX_EN] = rxSelEn;
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        rdMux = tmsel_pkg::WORD_RST;
        if (avs_address == tmsel_pkg::OFS_MCR) begin
            rdMux = mcrView;
        end
        for (int i = 0; i < tmsel_pkg::NUM_EN; i++) begin
            if (avs_address == tmsel_pkg::OFS_TXEN0 + tmsel_pkg::OFS_STEP * 6'(i)) begin
                rdMux = txEnReg[i];
            end
            if (avs_address == tmsel_pkg::OFS_RXEN0 + tmsel_pkg::OFS_STEP * 6'(i)) begin
                rdMux = rxEnReg[i];
            end
        end
    end

    // read data captured on the request and held through the answer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            avs_readdata <= tmsel_pkg::WORD_RST;
        end else if (busState == tmsel_pkg::BUS_IDLE && avs_read) begin
            avs_readdata <= rdMux;
        end
    end

    // writable control fields only; read-only and unused bits ignore writes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            txEnh <= 1'b0;
            txPartB <= tmsel_pkg::BLK_RST;
            txPartA <= tmsel_pkg::BLK_RST;
            txMode <= tmsel_pkg::TXM_ALL;
            rxEnh <= 1'b0;
            rxPartB <= tmsel_pkg::BLK_RST;
            rxPartA <= tmsel_pkg::BLK_RST;
            rxSelEn <= 1'b0;
        end else if (wrStrobe && avs_address == tmsel_pkg::OFS_MCR) begin
            // enhanced bits stick at zero on variants without them
            txEnh <= ENH_SUPPORT && avs_writedata[tmsel_pkg::POS_TX_ENH];
            rxEnh <= ENH_SUPPORT && avs_writedata[tmsel_pkg::POS_RX_ENH];
            txPartB <= avs_writedata[tmsel_pkg::POS_TX_B +: 2];
            txPartA <= avs_writedata[tmsel_pkg::POS_TX_A +: 2];
            txMode <= tmsel_pkg::tmsel_txmode_e'(avs_writedata[tmsel_pkg::POS_TX_MODE +: 2]);
            rxPartB <= avs_writedata[tmsel_pkg::POS_RX_B +: 2];
            rxPartA <= avs_writedata[tmsel_pkg::POS_RX_A +: 2];
            rxSelEn <= avs_writedata[tmsel_pkg::POS_RX_EN];
        end
    end

    // channel enable words, one per entry
    for (genvar g = 0; g < tmsel_pkg::NUM_EN; g++) begin : gEnReg
        always_ff @(posedge clk_sys) begin
            if (reset) begin
                txEnReg[g] <= tmsel_pkg::WORD_RST;
                rxEnReg[g] <= tmsel_pkg::WORD_RST;
            end else if (wrStrobe) begin
                if (avs_address == tmsel_pkg::OFS_TXEN0 + tmsel_pkg::OFS_STEP * 6'(g)) begin
                    txEnReg[g] <= avs_writedata;
                end
                if (avs_address == tmsel_pkg::OFS_RXEN0 + tmsel_pkg::OFS_STEP * 6'(g)) begin
                    rxEnReg[g] <= avs_writedata;
                end
            end
        end
    end

    // per-direction slot position
    tmsel_slot_counter uTxCnt (
        .clk_sys(clk_sys),
        .reset(reset),
        .slot(txSlot),
        .chan(txChan),
        .curBlock(txCurBlock),
        .slotStart(txStart)
    );

    tmsel_slot_counter uRxCnt (
        .clk_sys(clk_sys),
        .reset(reset),
        .slot(rxSlot),
        .chan(rxChan),
        .curBlock(rxCurBlock),
        .slotStart(rxStart)
    );

    // selection lookups for the current slots
    assign txHit = chanSel(txChan, txPartA, txPartB, txEnh, txEnReg);
    assign rxHitTx = chanSel(txChan, rxPartA, rxPartB, rxEnh, rxEnReg);
    assign rxHit = chanSel(rxChan, rxPartA, rxPartB, rxEnh, rxEnReg);

    // transmit enable and mask by mode
    always_comb begin
        case (txMode)
            tmsel_pkg::TXM_ALL: begin
                txEnabled = 1'b1;
                txUnmasked = 1'b1;
            end
            tmsel_pkg::TXM_SEL: begin
                txEnabled = txHit;
                txUnmasked = txHit;
            end
            tmsel_pkg::TXM_MASK: begin
                txEnabled = 1'b1;
                txUnmasked = txHit;
            end
            tmsel_pkg::TXM_SYM: begin
                // receive partitions steer both; transmit enables unmask
                txEnabled = rxHitTx;
                txUnmasked = rxHitTx && chanSel(txChan, rxPartA, rxPartB, txEnh, txEnReg);
            end
            default: begin
                txEnabled = 1'b0;
                txUnmasked = 1'b0;
            end
        endcase
    end

    // an enabled slot consumes a word even when masked, keeping the stream aligned
    assign fifoPop = txStart && txEnabled;

    tmsel_fifo #(
        .WIDTH(tmsel_pkg::DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) uTxFifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .inData(txWordData),
        .inValid(txWordValid),
        .inReady(txWordReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(fifoPop)
    );

    // output drive: enable low while driving, released in gaps
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            serialDataOutEn_n <= 1'b1;
        end else if (txSlot.gap) begin
            serialDataOutEn_n <= 1'b1;
        end else if (txStart) begin
            serialDataOutEn_n <= !(txEnabled && txUnmasked);
        end
    end

    // underrun sends zero rather than stale data
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            serialDataOut <= tmsel_pkg::WORD_RST;
        end else if (fifoPop) begin
            serialDataOut <= fifoValid ? fifoData : tmsel_pkg::WORD_RST;
        end
    end

    // receive slot qualification
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rxChanEnabled <= 1'b0;
        end else begin
            rxChanEnabled <= rxStart && (!rxSelEn || rxHit);
        end
    end

    AST_RSV_ZERO: assert property (@(posedge clk_sys) disable iff (reset)
        !avs_waitrequest && avs_read && avs_address == tmsel_pkg::OFS_MCR
            |-> avs_readdata[31:26] == 6'h00 && avs_readdata[15:10] == 6'h00
            && !avs_readdata[1])
        else $error("reserved bits read nonzero");

    AST_ENH_GATE: assert property (@(posedge clk_sys) disable iff (reset)
        !ENH_SUPPORT |-> !txEnh && !rxEnh)
        else $error("enhanced mode set on variant without it");

    AST_CUR_CLEAR: assert property (@(posedge clk_sys) disable iff (reset)
        txSlot.frameSync |=> txCurBlock == 3'h0 && txStart)
        else $error("current block not cleared on frame sync");

    AST_MODE_ALL: assert property (@(posedge clk_sys) disable iff (reset)
        txStart && txMode == tmsel_pkg::TXM_ALL && !txSlot.gap |=> !serialDataOutEn_n)
        else $error("mode 0 slot not driven");

    AST_GAP_MASK: assert property (@(posedge clk_sys) disable iff (reset)
        txSlot.gap |=> serialDataOutEn_n)
        else $error("output driven in packet gap");

    AST_MODE_SEL: assert property (@(posedge clk_sys) disable iff (reset)
        txStart && txMode == tmsel_pkg::TXM_SEL && !txHit |-> !fifoPop ##1 serialDataOutEn_n)
        else $error("unselected channel used in mode 1");

    AST_MODE_MASK: assert property (@(posedge clk_sys) disable iff (reset)
        txStart && txMode == tmsel_pkg::TXM_MASK && !txSlot.gap |-> fifoPop ##1 serialDataOutEn_n == !txHit)
        else $error("mode 2 enable or mask wrong");

    AST_MODE_SYM: assert property (@(posedge clk_sys) disable iff (reset)
        txStart && txMode == tmsel_pkg::TXM_SYM |-> fifoPop == rxHitTx)
        else $error("mode 3 enable not following receive selection");

    AST_RX_ALL: assert property (@(posedge clk_sys) disable iff (reset)
        rxStart && !rxSelEn |=> rxChanEnabled)
        else $error("receive slot dropped with selection off");

    AST_BUS_ANSWER: assert property (@(posedge clk_sys) disable iff (reset)
        busState == tmsel_pkg::BUS_IDLE && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");
endmodule // tmsel_select

// ### tmsel_tdm_partner.sv
// far-side tdm device model: slot strobes out, transmit pin captured per slot
`timescale 1ns/1ps
module tmsel_tdm_partner (
    input wire logic clk_sys,
    output tmsel_pkg::tmsel_slot_s txSlot,
    output tmsel_pkg::tmsel_slot_s rxSlot,
    input wire logic [31:0] serialDataOut,
    input wire logic serialDataOutEn_n,
    input wire logic rxChanEnabled
);
    logic [31:0] capData [128];
    logic capEn_n [128];
    logic capRx [128];
    logic idleEn_n;

    // idle between frames: no strobes, gap high
    initial begin
        txSlot = '{frameSync: 1'b0, slotTick: 1'b0, gap: 1'b1};
        rxSlot = '{frameSync: 1'b0, slotTick: 1'b0, gap: 1'b1};
    end

    // one frame of n slots, four cycles apart; the slot clock stands still outside frames
    task automatic runFrame(input int n);
        for (int s = 0; s < n; s++) begin
            @(posedge clk_sys);
            txSlot <= '{frameSync: (s == 0), slotTick: (s != 0), gap: 1'b0};
            rxSlot <= '{frameSync: (s == 0), slotTick: (s != 0), gap: 1'b0};
            @(posedge clk_sys);
            txSlot <= '{frameSync: 1'b0, slotTick: 1'b0, gap: 1'b0};
            rxSlot <= '{frameSync: 1'b0, slotTick: 1'b0, gap: 1'b0};
            // receive pulse lives one cycle only, so catch it right after it rises
            @(posedge clk_sys);
            #1 capRx[s] = rxChanEnabled;
            @(posedge clk_sys);
            #1 capEn_n[s] = serialDataOutEn_n;
            capData[s] = serialDataOut;
        end
        @(posedge clk_sys);
        txSlot <= '{frameSync: 1'b0, slotTick: 1'b0, gap: 1'b1};
        rxSlot <= '{frameSync: 1'b0, slotTick: 1'b0, gap: 1'b1};
        // margin of two edges beyond the promised release
        repeat (3) @(posedge clk_sys);
        #1 idleEn_n = serialDataOutEn_n;
    endtask
endmodule // tmsel_tdm_partner

// ### tmsel_tb.sv
// self-checking bench for the tdm multichannel selection block
`timescale 1ns/1ps
`define CHECK(got, exp) begin \
    nChecks++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module tb;
    localparam logic [5:0] MULTICHANNEL_CONTROL = tmsel_pkg::OFS_MCR;
    localparam logic [5:0] TX0 = tmsel_pkg::OFS_TXEN0;
    localparam logic [5:0] RX0 = tmsel_pkg::OFS_RXEN0;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [31:0] txWordData;
    logic txWordValid;
    logic txWordReady;
    tmsel_pkg::tmsel_slot_s txSlot;
    tmsel_pkg::tmsel_slot_s rxSlot;
    logic [31:0] serialDataOut;
    logic serialDataOutEn_n;
    logic rxChanEnabled;
    int mismatches = 0;
    int nChecks = 0;

    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;

    tmsel_select i_dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .txWordData(txWordData), .txWordValid(txWordValid),
        .txWordReady(txWordReady), .txSlot(txSlot), .rxSlot(rxSlot), .serialDataOut(serialDataOut),
        .serialDataOutEn_n(serialDataOutEn_n), .rxChanEnabled(rxChanEnabled));

    tmsel_tdm_partner i_far (.clk_sys(clk_sys), .txSlot(txSlot), .rxSlot(rxSlot), .serialDataOut(serialDataOut),
        .serialDataOutEn_n(serialDataOutEn_n), .rxChanEnabled(rxChanEnabled));

    // control word from its fields, unused bits zero
    function automatic logic [31:0] mcrWord(input logic txEnh, input logic [1:0] txB, input logic [1:0] txA,
        input logic [1:0] mode, input logic rxEnh, input logic [1:0] rxB, input logic [1:0] rxA, input logic rxEn);
        return {6'h00, txEnh, txB, txA, 3'h0, mode, 6'h00, rxEnh, rxB, rxA, 3'h0, 1'b0, rxEn};
    endfunction

    // trailing idle edge keeps requests apart
    task automatic busWrite(input logic [5:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic checkReg(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] d;
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk_sys);
        `CHECK(d, exp)
    endtask

    // eight words in a row, valid held high until the last is taken
    task automatic fill(input logic [31:0] base);
        for (int i = 0; i < 8; i++) begin
            txWordData <= base + i;
            txWordValid <= 1'b1;
            do @(posedge clk_sys); while (txWordReady !== 1'b1);
        end
        txWordValid <= 1'b0;
        @(posedge clk_sys);
        `CHECK(txWordReady, 1'b0)
    endtask

    // per-slot drive and receive pattern against the expected channel sets
    task automatic checkSlots(input int n, input logic [127:0] txOn, input logic [127:0] rxOn);
        for (int s = 0; s < n; s++) begin
            `CHECK(i_far.capEn_n[s], ~txOn[s])
            `CHECK(i_far.capRx[s], rxOn[s])
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        logic [127:0] txOn;
        logic [127:0] rxOn;
        // bus and stream inputs idle while reset is held
        avs_address <= 6'h00;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= 32'h00000000;
        txWordData <= 32'h00000000;
        txWordValid <= 1'b0;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        checkReg(MULTICHANNEL_CONTROL, 32'h00000000);
        busWrite(MULTICHANNEL_CONTROL, 32'hFFFFFFFF);
        checkReg(MULTICHANNEL_CONTROL, 32'h03E303E1);
        busWrite(6'h3C, 32'hA5A5A5A5);
        checkReg(6'h3C, 32'h00000000);
        busWrite(TX0 + 6'h0C, 32'h5A5A0F0F);
        checkReg(TX0 + 6'h0C, 32'h5A5A0F0F);
        // mode 0: every slot driven, fifo drained then underrun gives zero
        busWrite(MULTICHANNEL_CONTROL, 32'h00000000);
        busWrite(TX0 + 6'h0C, 32'h00000000);
        fill(32'h10000000);
        i_far.runFrame(40);
        checkSlots(40, '1, '1);
        for (int s = 0; s < 40; s++) begin
            `CHECK(i_far.capData[s], (s < 8) ? 32'h10000000 + s : 32'h00000000)
        end
        `CHECK(i_far.idleEn_n, 1'b1)
        checkReg(MULTICHANNEL_CONTROL, 32'h00080008);
        i_far.runFrame(1);
        checkReg(MULTICHANNEL_CONTROL, 32'h00000000);
        // mode 1 with every partition value; b fields run opposite to a fields
        busWrite(TX0, 32'h00200008);
        busWrite(RX0, 32'h02000080);
        for (int j = 0; j < 4; j++) begin
            busWrite(MULTICHANNEL_CONTROL, mcrWord(1'b0, 2'(3 - j), 2'(j), tmsel_pkg::TXM_SEL, 1'b0, 2'(3 - j), 2'(j), 1'b1));
            txOn = '0;
            rxOn = '0;
            txOn[32 * j + 3] = 1'b1;
            txOn[32 * (3 - j) + 21] = 1'b1;
            rxOn[32 * j + 7] = 1'b1;
            rxOn[32 * (3 - j) + 25] = 1'b1;
            i_far.runFrame(128);
            checkSlots(128, txOn, rxOn);
        end
        // mode 2: masked slots still consume words, so channel 3 carries the fourth
        fill(32'h20000000);
        busWrite(TX0, 32'h00000008);
        busWrite(MULTICHANNEL_CONTROL, mcrWord(1'b0, 2'h0, 2'h0, tmsel_pkg::TXM_MASK, 1'b0, 2'h0, 2'h0, 1'b0));
        i_far.runFrame(8);
        checkSlots(8, 128'h8, '1);
        `CHECK(i_far.capData[3], 32'h20000003)
        // mode 3: enabled by receive selection, unmasked by transmit bits
        fill(32'h30000000);
        busWrite(TX0, 32'h00000020);
        busWrite(RX0, 32'h00000024);
        busWrite(MULTICHANNEL_CONTROL, mcrWord(1'b0, 2'h0, 2'h1, tmsel_pkg::TXM_SYM, 1'b0, 2'h0, 2'h0, 1'b1));
        i_far.runFrame(8);
        checkSlots(8, 128'h20, 128'h24);
        `CHECK(i_far.capData[5], 32'h30000001)
        // enhanced: any of the 128 channels through the wide enable words
        busWrite(TX0, 32'h00000000);
        busWrite(RX0, 32'h00000000);
        busWrite(TX0 + 6'h08, 32'h00000001);
        busWrite(TX0 + 6'h0C, 32'h80000000);
        busWrite(RX0 + 6'h04, 32'h00000002);
        busWrite(MULTICHANNEL_CONTROL, mcrWord(1'b1, 2'h0, 2'h0, tmsel_pkg::TXM_SEL, 1'b1, 2'h0, 2'h0, 1'b1));
        i_far.runFrame(128);
        txOn = '0;
        txOn[64] = 1'b1;
        txOn[127] = 1'b1;
        checkSlots(128, txOn, 128'h2 << 32);
        checkReg(MULTICHANNEL_CONTROL, 32'h021D021D);
        results();
    end

    // watchdog: the sequence needs about 3000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        results();
    end
endmodule // tb
